// File: bit_check_timing_config.sv
// bit-check limits, bit-rate range and transmit bit clock configuration block
//
// Behaviour
// - check count code 00/01/10/11 selects 0/3/6/9 bits; resets to 3 bits
// - RX minimum interval is short limit times extended period; resets to 16
// - TX half bit lasts short limit plus one extended periods
// - rate range 00..11 gives 8,4,2,1 decoder periods times extension factor
// - rate range resets to code 10, two decoder periods per extended period
// - maximum interval is long limit minus one extended periods; resets to 27
// - limit extension bit doubles the extended period when set; resets clear
`include "bit_check_timing_config_map.svh"
`default_nettype none

module bit_check_timing_config (
    // clock, reset, enable
    input  wire logic                                clk_i,
    input  wire logic                                rst_b_i,
    input  wire logic                                ce_i,
    // register port from the serial interface decoder
    input  wire logic                                wr_en_i,
    input  wire logic                                rd_en_i,
    input  wire logic [3:0]                          addr_i,
    input  wire logic [7:0]                          wdata_i,
    output logic      [7:0]                          rd_data_o,
    // decoder clock and mode
    input  wire logic                                dclk_tick_i,
    input  wire logic                                tx_mode_i,
    // bit check control and received data pin
    input  wire logic                                check_start_i,
    input  wire logic                                check_stop_i,
    input  wire logic                                rx_data_i,
    // results
    output bit_check_timing_config_pkg::check_state_t check_state_o,
    output logic                                     check_ok_o,
    output logic                                     check_fail_o,
    output logic                                     xdclk_tick_o,
    output logic                                     tx_bit_clk_o
);
    import bit_check_timing_config_pkg::*;

    core_state_t r_reg;
    core_state_t r_next;

    // number of bits to check for a check-count code
    function automatic logic [3:0] check_bits(input logic [1:0] code);
        case (code)
            2'h0:    check_bits = `CHECK_BITS_CODE0;
            2'h1:    check_bits = `CHECK_BITS_CODE1;
            2'h2:    check_bits = `CHECK_BITS_CODE2;
            default: check_bits = `CHECK_BITS_CODE3;
        endcase
    endfunction : check_bits

    // the extension bit doubles the divider before the terminal count is taken
    // decoder clock periods in one extended period
    function automatic logic [4:0] xdclk_div(input logic [1:0] range, input logic ext);
        logic [4:0] base;
        case (range)
            2'h0:    base = `RANGE_DIV_CODE0;
            2'h1:    base = `RANGE_DIV_CODE1;
            2'h2:    base = `RANGE_DIV_CODE2;
            default: base = `RANGE_DIV_CODE3;
        endcase
        xdclk_div = ext ? 5'(base << 1) : base;
    endfunction : xdclk_div

    // limits below the legal floor are not blocked here; software keeps them in range
    // field views of the registers
    logic [1:0] check_code;
    logic [1:0] rate_range;
    logic [5:0] short_limit;
    logic [5:0] long_limit;
    logic [3:0] check_target;
    logic [4:0] div_last;
    logic       rx_edge;
    logic [6:0] min_interval;
    logic [6:0] max_interval;

    assign check_code   = r_reg.short_limit_reg[`CHECK_COUNT_MSB:`CHECK_COUNT_LSB];
    assign rate_range   = r_reg.long_limit_reg[`RATE_RANGE_MSB:`RATE_RANGE_LSB];
    assign short_limit  = r_reg.short_limit_reg[`LIMIT_MSB:`LIMIT_LSB];
    assign long_limit   = r_reg.long_limit_reg[`LIMIT_MSB:`LIMIT_LSB];
    assign check_target = check_bits(check_code);
    assign div_last     = 5'(xdclk_div(rate_range, r_reg.limit_ext_reg) - 5'h01);
    assign rx_edge      = r_reg.rx_sync[1] ^ r_reg.rx_prev;
    assign min_interval = {1'b0, short_limit};
    assign max_interval = 7'({1'b0, long_limit} - 7'h01);

    // next-state logic for the whole block
    always_comb begin
        r_next = r_reg;
        r_next.xdclk_tick = 1'b0;

        // register writes
        if (wr_en_i) begin
            case (addr_i)
                `LIMIT_EXT_ADDR:   r_next.limit_ext_reg = wdata_i[`LIMIT_EXT_BIT];
                `SHORT_LIMIT_ADDR: r_next.short_limit_reg = wdata_i;
                `LONG_LIMIT_ADDR:  r_next.long_limit_reg = wdata_i;
                default:           r_next.limit_ext_reg = r_reg.limit_ext_reg;
            endcase
        end

        // read data holds until the next read so a slow shifter can fetch it
        // register reads, unmapped addresses read zero
        if (rd_en_i) begin
            case (addr_i)
                `LIMIT_EXT_ADDR:   r_next.rd_data = {7'h00, r_reg.limit_ext_reg};
                `SHORT_LIMIT_ADDR: r_next.rd_data = r_reg.short_limit_reg;
                `LONG_LIMIT_ADDR:  r_next.rd_data = r_reg.long_limit_reg;
                default:           r_next.rd_data = 8'h00;
            endcase
        end

        // the pin is asynchronous: only the second flop feeds the edge compare
        // received data pin synchroniser and edge memory
        r_next.rx_sync = {r_reg.rx_sync[0], rx_data_i};
        r_next.rx_prev = r_reg.rx_sync[1];

        // extended decoder clock from decoder clock ticks
        if (dclk_tick_i) begin
            if (r_reg.dclk_cnt >= div_last) begin
                r_next.dclk_cnt   = 5'h00;
                r_next.xdclk_tick = 1'b1;
            end else begin
                r_next.dclk_cnt = 5'(r_reg.dclk_cnt + 5'h01);
            end
        end

        // the interval saturates so a very long gap cannot wrap into a legal value
        // bit-check sequencer
        case (r_reg.state)
            CHECK_IDLE: begin
                if (check_start_i && !tx_mode_i) begin
                    r_next.interval   = 7'h00;
                    r_next.bit_cnt    = 4'h0;
                    r_next.check_ok   = 1'b0;
                    r_next.check_fail = 1'b0;
                    if (check_target == 4'h0) begin
                        r_next.state    = CHECK_PASS;
                        r_next.check_ok = 1'b1;
                    end else begin
                        r_next.state = CHECK_RUN;
                    end
                end
            end
            CHECK_RUN: begin
                if (check_stop_i || tx_mode_i) begin
                    r_next.state = CHECK_IDLE;
                end else if (rx_edge) begin
                    r_next.interval = 7'h00;
                    if (r_reg.interval >= min_interval && r_reg.interval <= max_interval) begin
                        r_next.bit_cnt = 4'(r_reg.bit_cnt + 4'h1);
                        if (4'(r_reg.bit_cnt + 4'h1) >= check_target) begin
                            r_next.state    = CHECK_PASS;
                            r_next.check_ok = 1'b1;
                        end
                    end else begin
                        r_next.state      = CHECK_FAIL;
                        r_next.check_fail = 1'b1;
                    end
                end else if (r_reg.interval > max_interval) begin
                    r_next.state      = CHECK_FAIL;
                    r_next.check_fail = 1'b1;
                end else if (r_reg.xdclk_tick && r_reg.interval != `INTERVAL_SAT) begin
                    r_next.interval = 7'(r_reg.interval + 7'h01);
                end
            end
            CHECK_PASS, CHECK_FAIL: begin
                if (check_stop_i || check_start_i) begin
                    r_next.state      = CHECK_IDLE;
                    r_next.check_ok   = 1'b0;
                    r_next.check_fail = 1'b0;
                end
            end
            default: begin
                r_next.state = CHECK_IDLE;
            end
        endcase

        // the count clears in RX so the first half bit in TX has full length
        // transmit bit clock: each half bit is short limit plus one extended periods
        if (tx_mode_i) begin
            if (r_reg.xdclk_tick) begin
                if (r_reg.tx_cnt >= short_limit) begin
                    r_next.tx_cnt     = 6'h00;
                    r_next.tx_bit_clk = ~r_reg.tx_bit_clk;
                end else begin
                    r_next.tx_cnt = 6'(r_reg.tx_cnt + 6'h01);
                end
            end
        end else begin
            r_next.tx_cnt     = 6'h00;
            r_next.tx_bit_clk = 1'b0;
        end
    end

    // a low enable also stalls the synchroniser, so pin edges are seen late
    // state register, frozen while the clock enable is low
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            r_reg                 <= '0;
            r_reg.limit_ext_reg   <= `LIMIT_EXT_RESET;
            r_reg.short_limit_reg <= `SHORT_LIMIT_RESET;
            r_reg.long_limit_reg  <= `LONG_LIMIT_RESET;
            r_reg.state           <= CHECK_IDLE;
        end else if (ce_i) begin
            r_reg <= r_next;
        end
    end

    // every output is a field of the state register, never a decode of one
    // outputs straight from the state register
    assign rd_data_o     = r_reg.rd_data;
    assign check_state_o = r_reg.state;
    assign check_ok_o    = r_reg.check_ok;
    assign check_fail_o  = r_reg.check_fail;
    assign xdclk_tick_o  = r_reg.xdclk_tick;
    assign tx_bit_clk_o  = r_reg.tx_bit_clk;

endmodule : bit_check_timing_config
`default_nettype wire

// File: bit_check_timing_config_map.svh
// register offsets, field positions, reset values and counts of the bit-check config block
`ifndef BIT_CHECK_TIMING_CONFIG_MAP_SVH
`define BIT_CHECK_TIMING_CONFIG_MAP_SVH

// register addresses on the serial register port
`define LIMIT_EXT_ADDR          4'h3
`define SHORT_LIMIT_ADDR        4'h4
`define LONG_LIMIT_ADDR         4'h5

// field positions
`define LIMIT_EXT_BIT           0
`define CHECK_COUNT_MSB         7
`define CHECK_COUNT_LSB         6
`define RATE_RANGE_MSB          7
`define RATE_RANGE_LSB          6
`define LIMIT_MSB               5
`define LIMIT_LSB               0

// reset values
`define LIMIT_EXT_RESET         1'h0
`define SHORT_LIMIT_RESET       8'h50
`define LONG_LIMIT_RESET        8'h9C

// check counts per code
`define CHECK_BITS_CODE0        4'h0
`define CHECK_BITS_CODE1        4'h3
`define CHECK_BITS_CODE2        4'h6
`define CHECK_BITS_CODE3        4'h9

// decoder clock periods per extended period, per rate-range code
`define RANGE_DIV_CODE0         5'h08
`define RANGE_DIV_CODE1         5'h04
`define RANGE_DIV_CODE2         5'h02
`define RANGE_DIV_CODE3         5'h01

// interval counter saturation value
`define INTERVAL_SAT            7'h7F

`endif

// File: bit_check_timing_config_pkg.sv
// types of the bit-check timing configuration block
`default_nettype none
package bit_check_timing_config_pkg;

    // bit-check sequencer, gray coded along idle-check-pass
    typedef enum logic [1:0] {
        CHECK_IDLE = 2'h0,
        CHECK_RUN  = 2'h1,
        CHECK_PASS = 2'h3,
        CHECK_FAIL = 2'h2
    } check_state_t;

    // complete state of the block
    typedef struct packed {
        logic         limit_ext_reg;
        logic [7:0]   short_limit_reg;
        logic [7:0]   long_limit_reg;
        logic [1:0]   rx_sync;
        logic         rx_prev;
        logic [4:0]   dclk_cnt;
        logic         xdclk_tick;
        logic [6:0]   interval;
        logic [3:0]   bit_cnt;
        check_state_t state;
        logic [5:0]   tx_cnt;
        logic         tx_bit_clk;
        logic [7:0]   rd_data;
        logic         check_ok;
        logic         check_fail;
    } core_state_t;

endpackage : bit_check_timing_config_pkg
`default_nettype wire

// File: bit_check_timing_config_assertions.sv
// port checker of the bit-check timing config block
`default_nettype none
module bit_check_timing_config_checker (
    // clock, reset and enable
    input wire logic                                      clk_i,
    input wire logic                                      rst_b_i,
    input wire logic                                      ce_i,
    // register port
    input wire logic                                      wr_en_i,
    input wire logic                                      rd_en_i,
    input wire logic [3:0]                                addr_i,
    input wire logic [7:0]                                wdata_i,
    input wire logic [7:0]                                rd_data_o,
    // decoder clock, mode and check control
    input wire logic                                      dclk_tick_i,
    input wire logic                                      tx_mode_i,
    input wire logic                                      check_start_i,
    input wire logic                                      check_stop_i,
    input wire logic                                      rx_data_i,
    // results
    input wire bit_check_timing_config_pkg::check_state_t check_state_o,
    input wire logic                                      check_ok_o,
    input wire logic                                      check_fail_o,
    input wire logic                                      xdclk_tick_o,
    input wire logic                                      tx_bit_clk_o
);
    import bit_check_timing_config_pkg::*;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    // a start that the sequencer must take
    sequence s_start;
        check_state_o == CHECK_IDLE && check_start_i && !check_stop_i && !tx_mode_i && ce_i;
    endsequence
    sequence s_begun;
        check_state_o inside {CHECK_RUN, CHECK_PASS};
    endsequence
    a_start_begins_run: assert property (s_start |=> s_begun)
        else $error("check start not taken");
    a_ok_in_pass: assert property (check_ok_o == (check_state_o == CHECK_PASS))
        else $error("ok flag does not follow pass state");
    a_fail_in_fail: assert property (check_fail_o == (check_state_o == CHECK_FAIL))
        else $error("fail flag does not follow fail state");
    a_stop_to_idle: assert property (check_stop_i && !check_start_i && ce_i
        |=> check_state_o == CHECK_IDLE) else $error("stop did not return to idle");
    a_result_holds: assert property (check_state_o inside {CHECK_PASS, CHECK_FAIL}
        && !check_start_i && !check_stop_i && ce_i |=> $stable(check_state_o))
        else $error("check result did not hold");
    a_tx_aborts_run: assert property (check_state_o == CHECK_RUN && tx_mode_i
        && !check_start_i && ce_i |=> check_state_o == CHECK_IDLE)
        else $error("transmit mode did not abort the check");
    a_tick_from_dclk: assert property (xdclk_tick_o && $past(ce_i) |-> $past(dclk_tick_i))
        else $error("extended tick without decoder tick");
    a_tx_clock_rx: assert property (!tx_mode_i && ce_i |=> !tx_bit_clk_o)
        else $error("transmit bit clock runs in receive mode");
    a_unmapped_zero: assert property (rd_en_i && ce_i
        && !(addr_i inside {4'h3, 4'h4, 4'h5}) |=> rd_data_o == 8'h00)
        else $error("unmapped read not zero");
    a_read_holds: assert property (!rd_en_i |=> $stable(rd_data_o))
        else $error("read data changed without a read");
endmodule : bit_check_timing_config_checker
bind bit_check_timing_config bit_check_timing_config_checker i_chk (.*);
`default_nettype wire

// File: mcu_model.sv
// microcontroller model driving the register port of the config block
`default_nettype none
module mcu_model (
    // clock
    input  wire logic       clk_i,
    // register port strobes, address and data
    output logic            wr_en_o,
    output logic            rd_en_o,
    output logic [3:0]      addr_o,
    output logic [7:0]      wdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {wr_en_o, rd_en_o, addr_o, wdata_o} = 14'h0000;
    // one strobe cycle per access, released lines show the inverse
    task automatic access(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #2 {wr_en_o, rd_en_o, addr_o, wdata_o} = {w, !w, a, d};
        @(posedge clk_i);
        #2 {wr_en_o, rd_en_o, addr_o, wdata_o} = {2'h0, ~a, ~d};
    endtask : access
    // limit fields kept in their legal range; no modulation choice here
    function automatic logic [7:0] legal(input logic [1:0] hi, input logic [31:0] r, int lo);
        return {hi, 6'(lo + r % (64 - lo))};
    endfunction : legal
endmodule : mcu_model
`default_nettype wire

// File: bit_check_timing_config_bench.sv
// self-checking bench of the bit-check timing config block
`default_nettype none
module bit_check_timing_config_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import bit_check_timing_config_pkg::*;
    logic         clk_i = 0, rst_b_i = 0, dclk_tick_i = 1, tx_mode_i = 0, rd_q = 0, ce_i = 1;
    logic         check_start_i = 0, check_stop_i = 0, rx_data_i = 0, wr_en_i, rd_en_i;
    logic [3:0]   addr_i;
    logic [7:0]   wdata_i, rd_data_o, exp_q[$];
    logic         check_ok_o, check_fail_o, xdclk_tick_o, tx_bit_clk_o;
    check_state_t check_state_o;
    int           err_count = 0, num_checks = 0, cycles = 0, n;
    logic [31:0]  seed = 32'hB9DA7AB0;
    bit_check_timing_config i_dut (.clk_i, .rst_b_i, .ce_i, .wr_en_i, .rd_en_i, .addr_i,
        .wdata_i, .rd_data_o, .dclk_tick_i, .tx_mode_i, .check_start_i, .check_stop_i,
        .rx_data_i, .check_state_o, .check_ok_o, .check_fail_o, .xdclk_tick_o, .tx_bit_clk_o);
    mcu_model i_mcu (.clk_i, .wr_en_o(wr_en_i), .rd_en_o(rd_en_i), .addr_o(addr_i),
        .wdata_o(wdata_i));
    initial forever #25 clk_i = ~clk_i;
    task automatic close_out();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : close_out
    // hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 30000) begin
            err_count++;
            close_out();
        end
    end
    task automatic check(input logic [7:0] seen, exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // read data watcher takes the oldest note
    always @(posedge clk_i) begin
        if (rd_q) check(rd_data_o, exp_q.pop_front());
        rd_q <= rd_en_i;
    end
    task automatic tick(input int k);
        repeat (k) @(posedge clk_i);
        #2;
    endtask : tick
    task automatic pulse(ref logic s);
        s = 1;
        tick(1);
        s = 0;
    endtask : pulse
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        i_mcu.access(1'b0, a, 8'h00);
    endtask : rd
    // cycles between the second and third extended tick or transmit clock change
    task automatic gap(input bit tx, output int p);
        logic last;
        int   hits;
        hits = 0;
        p = 0;
        last = tx_bit_clk_o;
        while (hits < 3) begin
            @(posedge clk_i);
            #1 if (tx ? tx_bit_clk_o !== last : xdclk_tick_o === 1'b1) hits++;
            last = tx_bit_clk_o;
            if (hits == 2) p++;
        end
    endtask : gap
    // start a check, toggle the pin k times every s-1 cycles, wait for the verdict
    task automatic run(input int k, input int s, input check_state_t f);
        pulse(check_start_i);
        for (int i = 0; i < k; i++) begin
            tick(s - 1);
            check(8'(check_state_o), 8'(CHECK_RUN));
            rx_data_i = ~rx_data_i;
        end
        for (int i = 0; i < 200 && check_state_o === CHECK_RUN; i++) tick(1);
        check(8'(check_state_o), 8'(f));
        check(8'(check_ok_o), 8'(f == CHECK_PASS));
        check(8'(check_fail_o), 8'(f == CHECK_FAIL));
        pulse(check_stop_i);
        tick(1);
    endtask : run
    initial begin
        repeat (4) @(posedge clk_i);
        #2 rst_b_i = 1;
        // a write to an unmapped place must not disturb the registers
        i_mcu.access(1'b1, 4'h6, 8'hFF);
        // reset values, unmapped places, unused bits
        rd(4'h3, 8'h00);
        rd(4'h4, 8'h50);
        rd(4'h5, 8'h9C);
        rd(4'h0, 8'h00);
        i_mcu.access(1'b1, 4'h3, 8'hFF);
        rd(4'h3, 8'h01);
        // a write while the clock enable is low is lost
        ce_i = 0;
        i_mcu.access(1'b1, 4'h4, 8'h3F);
        ce_i = 1;
        rd(4'h4, 8'h50);
        repeat (4) begin
            n = $random(seed);
            dclk_tick_i = n[16];
            i_mcu.access(1'b1, 4'h4, i_mcu.legal(n[7:6], n, 10));
            rd(4'h4, i_mcu.legal(n[7:6], n, 10));
            i_mcu.access(1'b1, 4'h5, i_mcu.legal(n[15:14], n >> 8, 12));
            rd(4'h5, i_mcu.legal(n[15:14], n >> 8, 12));
        end
        dclk_tick_i = 1;
        // extended period for every range and extension
        for (int e = 0; e < 2; e++) for (int r = 0; r < 4; r++) begin
            i_mcu.access(1'b1, 4'h3, 8'(e));
            i_mcu.access(1'b1, 4'h5, {2'(r), 6'h1C});
            gap(1'b0, n);
            check(8'(n), 8'((8 >> r) * (e + 1)));
        end
        // bit checks, one tick per cycle, limits 10 and 20
        i_mcu.access(1'b1, 4'h3, 8'h00);
        i_mcu.access(1'b1, 4'h5, 8'hD4);
        for (int c = 0; c < 4; c++) begin
            i_mcu.access(1'b1, 4'h4, {2'(c), 6'h0A});
            run(3 * c, 13, CHECK_PASS);
        end
        run(1, 5, CHECK_FAIL);
        run(0, 5, CHECK_FAIL);
        // transmit mode aborts, refuses a start, sets the bit clock
        pulse(check_start_i);
        tx_mode_i = 1;
        tick(2);
        pulse(check_start_i);
        tick(1);
        check(8'(check_state_o), 8'(CHECK_IDLE));
        for (int v = 10; v < 30; v += 10) begin
            i_mcu.access(1'b1, 4'h4, 8'(v));
            gap(1'b1, n);
            check(8'(n), 8'(v + 1));
        end
        tx_mode_i = 0;
        tick(3);
        close_out();
    end
endmodule : bit_check_timing_config_bench
`default_nettype wire
